// [verif/sepc_host.sv]
/*
 spi host model for the serial memory front end: frames up to four bytes
 msb first in mode 0 or 3, with an optional pause before one bit.
 assumes the bench calls frame from one process at a time.
*/
`timescale 1ns/1ns
`default_nettype none
module sepc_host (
  output logic serial_clk,
  output logic device_select_n,
  output logic serial_in,
  output logic pause_input_n,
  input wire logic serial_out,
  input wire logic serial_out_oe_n
);
  logic cpol;
  logic last_so;
  logic miso;
  // a released data line shows the inverse of its last driven level
  always @(serial_out or serial_out_oe_n) begin
    if (!serial_out_oe_n) begin
      last_so = serial_out;
    end
  end
  assign miso = serial_out_oe_n ? ~last_so : serial_out;
  // idle levels at time zero
  initial begin
    cpol = 1'b0;
    serial_clk = 1'b0;
    device_select_n = 1'b1;
    serial_in = 1'b0;
    pause_input_n = 1'b1;
  end
  // one framed transfer; rx collects the data line at every rising edge
  task automatic frame(input logic [31:0] tx, input int n, input int pbit,
                       output logic [31:0] rx);
    int i;
    #5;
    serial_clk = cpol;
    #80;
    device_select_n = 1'b0;
    #80;
    for (i = 0; i < n * 8; i++) begin
      serial_clk = 1'b0;
      if (i == pbit) begin
        #40;
        pause_input_n = 1'b0;
        #400;
        pause_input_n = 1'b1;
        #40;
      end
      serial_in = tx[31 - i];
      #80;
      serial_clk = 1'b1;
      rx[31 - i] = miso;
      #80;
    end
    serial_clk = cpol;
    #80;
    device_select_n = 1'b1;
    serial_in = ~serial_in;
    #160;
  endtask
endmodule
`default_nettype wire

// [verif/testbench.sv]
/*
 self-checking bench for the serial memory front end: latch commands,
 status writes, busy cycle, software and hardware protection, id page.
 assumes sepc_host as the spi host and a shortened write cycle.
*/
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import sepc_pkg::*;
  localparam int WCYC = 700;
  logic core_clk, arst_n, clk_en, write_guard_pin_n;
  logic serial_clk, device_select_n, serial_in, pause_input_n;
  logic serial_out, serial_out_oe_n;
  logic [7:0] status_control;
  logic [31:0] rx;
  int mismatches, checked, cycles;

  sepc_core #(.MAIN_WORDS(64), .WRITE_CYC(WCYC)) dut (.core_clk(core_clk),
    .arst_n(arst_n), .clk_en(clk_en), .serial_clk(serial_clk),
    .device_select_n(device_select_n), .serial_in(serial_in),
    .pause_input_n(pause_input_n), .write_guard_pin_n(write_guard_pin_n),
    .serial_out(serial_out), .serial_out_oe_n(serial_out_oe_n),
    .status_control(status_control));
  sepc_host host (.serial_clk(serial_clk), .device_select_n(device_select_n),
    .serial_in(serial_in), .pause_input_n(pause_input_n),
    .serial_out(serial_out), .serial_out_oe_n(serial_out_oe_n));

  // clock and hang guard
  always #4 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 80000) begin
      mismatches++;
      results();
    end
  end

  task automatic results();
    $display("checks %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk1(input string nm, input logic e, input logic g);
    checked++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] %s expected %b seen %b", nm, e, g);
    end
  endtask
  // bus helpers built on the host model
  task automatic xfer(input logic [31:0] t, input int n);
    host.frame(t, n, -1, rx);
  endtask
  task automatic wait_idle();
    int k;
    for (k = 0; k < WCYC + 50 && status_control[SB_BUSY] !== 1'b0; k++) begin
      @(posedge core_clk);
    end
  endtask
  task automatic guard(input logic v);
    @(posedge core_clk);
    #1;
    write_guard_pin_n = v;
  endtask
  task automatic status_write_cmd(input logic [7:0] v);
    xfer({OP_SET_WRITE_LATCH, 24'h0}, 1);
    xfer({OP_STATUS_WRITE, v, 16'h0}, 2);
    wait_idle();
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    xfer({OP_SET_WRITE_LATCH, 24'h0}, 1);
    xfer({OP_MEM_WRITE, a, d}, 4);
    wait_idle();
  endtask
  task automatic rd(input string nm, input logic [15:0] a, input logic [7:0] e);
    xfer({OP_MEM_READ, a, 8'h00}, 4);
    chk8(nm, e, rx[7:0]);
  endtask
  task automatic status_read_cmd(input logic [7:0] e);
    xfer({OP_STATUS_READ, 24'h0}, 2);
    chk8("status read", e, rx[23:16]);
    repeat (6) @(posedge core_clk);
    chk1("output released", 1'b1, serial_out_oe_n);
  endtask

  // scenarios
  task automatic t_latch();
    chk8("status at reset", STATUS_RESET, status_control);
    xfer({OP_SET_WRITE_LATCH, 24'h0}, 1);
    chk1("latch set", 1'b1, status_control[SB_WEL]);
    status_read_cmd(8'h02);
    xfer({8'hff, 24'h0}, 1);
    chk1("latch after unknown", 1'b1, status_control[SB_WEL]);
    xfer({OP_CLEAR_WRITE_LATCH, 24'h0}, 1);
    chk1("latch cleared", 1'b0, status_control[SB_WEL]);
    host.cpol = 1'b1;
    xfer({OP_SET_WRITE_LATCH, 24'h0}, 1);
    status_read_cmd(8'h02);
    xfer({OP_CLEAR_WRITE_LATCH, 24'h0}, 1);
    host.cpol = 1'b0;
  endtask
  task automatic t_busy();
    xfer({OP_SET_WRITE_LATCH, 24'h0}, 1);
    xfer({OP_STATUS_WRITE, 8'h8c, 16'h0}, 2);
    chk1("busy after select rise", 1'b1, status_control[SB_BUSY]);
    xfer({OP_SET_WRITE_LATCH, 24'h0}, 1);
    xfer({OP_STATUS_READ, 24'h0}, 2);
    chk8("status read while busy", 8'hff, rx[23:16]);
    wait_idle();
    chk8("status after cycle", 8'h8c, status_control);
  endtask
  task automatic t_guard();
    guard(1'b0);
    status_write_cmd(8'h00);
    chk8("guarded status", 8'h8c, status_control & 8'hfc);
    guard(1'b1);
    status_write_cmd(8'h00);
    chk8("unguarded status", 8'h00, status_control);
    guard(1'b0);
    status_write_cmd(8'h04);
    chk8("enable off status", 8'h04, status_control);
    guard(1'b1);
  endtask
  task automatic t_protect();
    // 64 backing words: 6001 and 5fc1 alias 0001
    wr(16'h0001, 8'h5a);
    rd("plain write", 16'h0001, 8'h5a);
    wr(16'h6001, 8'ha5);
    rd("quarter protect", 16'h0001, 8'h5a);
    wr(16'h5fc1, 8'h3c);
    rd("below quarter", 16'h0001, 8'h3c);
    xfer({OP_MEM_WRITE, 16'h0001, 8'h99}, 4);
    wait_idle();
    rd("latch clear write", 16'h0001, 8'h3c);
    host.frame({OP_MEM_READ, 16'h0001, 8'h00}, 4, 12, rx);
    chk8("paused read", 8'h3c, rx[7:0]);
    status_write_cmd(8'h84);
    guard(1'b0);
    wr(16'h0001, 8'h61);
    rd("guarded open", 16'h0001, 8'h61);
    wr(16'h6001, 8'h62);
    rd("guarded block", 16'h0001, 8'h61);
    guard(1'b1);
    status_write_cmd(8'h00);
  endtask
  task automatic t_idpage();
    status_write_cmd(8'h50);
    chk8("select with lock", 8'h00, status_control);
    status_write_cmd(8'h40);
    chk1("select set", 1'b1, status_control[SB_SEL]);
    wr(16'h0001, 8'h77);
    chk1("select after write", 1'b0, status_control[SB_SEL]);
    rd("main untouched", 16'h0001, 8'h61);
    status_write_cmd(8'h40);
    rd("id page read", 16'h0001, 8'h77);
    chk1("select after read", 1'b0, status_control[SB_SEL]);
    status_write_cmd(8'h10);
    chk1("lock set", 1'b1, status_control[SB_LOCK]);
    status_write_cmd(8'h40);
    wr(16'h0001, 8'h11);
    status_write_cmd(8'h40);
    rd("locked page", 16'h0001, 8'h77);
  endtask

  // reset, then the scenarios in order
  initial begin
    core_clk = 1'b0;
    arst_n = 1'b0;
    clk_en = 1'b1;
    write_guard_pin_n = 1'b1;
    cycles = 0;
    mismatches = 0;
    checked = 0;
    repeat (2) @(posedge core_clk);
    #1;
    arst_n = 1'b1;
    repeat (10) @(posedge core_clk);
    t_latch();
    t_busy();
    t_guard();
    t_protect();
    t_idpage();
    results();
  end
endmodule
`default_nettype wire

// [verilog/sepc_core.sv]
/*
 serial slave front end of a byte memory: instruction decode, status and
 control register, software and hardware write protection, self-timed
 write cycle, small storage for main array window and identification page.
 assumes an spi host in mode 0 or 3 with sck far slower than core_clk.
*/
// Notes on behaviour
// [R1] sample input on rising sck, modes 0 and 3
// [R2] shift output bits on falling sck
// [R3] deselected: output released, writes still finish
// [R4] host frames each transaction with select
// [R5] host pauses with pause pin, sck low
// [R6] only six opcodes act; others ignored
// [R7] 03 memory read, 05 status read
// [R8] 02 memory write, 01 status write
// [R9] 06 sets write latch, 04 clears
// [R10] status bit layout fixed, bit5 zero
// [R11] busy bit high during write cycle
// [R12] block protect bits select read-only range
// [R13] guard low with enable blocks status, protected
// [R14] guard high or enable off: no hardware protect
// [R15] latch clear rejects every write
// [R16] id select routes access, clears after use
// [R17] separate 64 byte identification page
// [R18] id lock makes page read-only forever
// [R19] select and lock together: both unchanged
// [R20] power-up write-disabled; protected range refused
// [R21] write cycle starts at select rise
// [R22] host waits after power before access
// [R23] busy: only status read accepted
`timescale 1ns/1ns
`default_nettype none
module sepc_core #(
  parameter int MAIN_WORDS = 64,
  parameter int WRITE_CYC = sepc_pkg::WRITE_CYCLE_CYC
) (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic clk_en,
  input wire logic serial_clk,
  input wire logic device_select_n,
  input wire logic serial_in,
  input wire logic pause_input_n,
  input wire logic write_guard_pin_n,
  output logic serial_out,
  output logic serial_out_oe_n,
  output logic [7:0] status_control
);
  import sepc_pkg::*;

  localparam int MW_BITS = $clog2(MAIN_WORDS);
  localparam int IP_BITS = $clog2(ID_PAGE_BYTES);
  localparam int CNT_W = $clog2(WRITE_CYC + 1);

  initial begin
    if (MAIN_WORDS < 2 || MAIN_WORDS > 32768 || WRITE_CYC < 1) begin
      $error("sepc_core: unsupported parameters");
    end
  end

  sepc_sync_if sy ();

  sepc_pin_sync u_sync (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .clk_en(clk_en),
    .pins_in({serial_in, write_guard_pin_n, pause_input_n, device_select_n, serial_clk}),
    .sy(sy)
  );

  typedef struct packed {
    sepc_phase_t phase;
    logic [7:0] cmd;
    logic [7:0] sh;
    logic [4:0] bits;
    logic [15:0] addr;
    logic [7:0] status;
    logic [7:0] wr_data;
    logic [7:0] wr_status;
    logic wr_valid;
    logic wr_is_status;
    logic wr_is_id;
    logic [14:0] wr_addr;
    logic [CNT_W-1:0] busy_cnt;
    logic so;
    logic so_oe_n;
  } sepc_state_t;

  sepc_state_t st_q, st_d;
  logic [7:0] main_mem [MAIN_WORDS];
  logic [7:0] id_mem [ID_PAGE_BYTES];
  logic commit;

  // true when an array address falls in the block-protected range
  function automatic logic in_protected(input logic [1:0] bp, input logic [14:0] a);
    unique case (bp)
      2'b00: in_protected = 1'b0;
      2'b01: in_protected = (a >= BP_QUARTER);
      2'b10: in_protected = (a >= BP_HALF);
      default: in_protected = 1'b1;
    endcase
  endfunction

  // read byte at current pointer, from the page or the array
  function automatic logic [7:0] read_byte(input logic id_sel, input logic [15:0] a);
    if (id_sel) begin
      read_byte = id_mem[a[IP_BITS-1:0]];
    end else begin
      read_byte = main_mem[a[MW_BITS-1:0]];
    end
  endfunction

  logic hw_protect;
  logic busy;
  logic active;
  assign busy = st_q.status[SB_BUSY];
  assign hw_protect = !sy.guard_n && st_q.status[SB_PPE]; // R13 R14
  assign active = !sy.sel_n && sy.pause_n; // R5

  // main sequencer: shift in on rise, shift out on fall, commit on select rise
  always_comb begin
    logic [7:0] nb;
    logic [7:0] ns;
    logic [7:0] stat_out;
    nb = {st_q.sh[6:0], sy.sdi};
    ns = st_q.status;
    stat_out = st_q.status;
    commit = 1'b0;
    st_d = st_q;
    // write cycle countdown, runs even when deselected
    if (busy) begin // R3 R11
      if (st_q.busy_cnt <= CNT_W'(1)) begin
        st_d.status[SB_BUSY] = 1'b0;
        st_d.status[SB_WEL] = 1'b0; // back to write-disabled after a write
        st_d.busy_cnt = '0;
      end else begin
        st_d.busy_cnt = st_q.busy_cnt - CNT_W'(1);
      end
    end
    if (sy.sel_n || !sy.pause_n) begin
      st_d.so_oe_n = 1'b1; // R3
    end
    if (sy.sel_fall) begin // R4
      st_d.phase = SEPC_CMD;
      st_d.bits = '0;
      st_d.wr_valid = 1'b0;
    end else if (sy.sel_rise) begin
      st_d.phase = SEPC_IDLE;
      st_d.so_oe_n = 1'b1;
      if (st_q.wr_valid && !busy) begin // R21
        commit = 1'b1;
        st_d.status[SB_BUSY] = 1'b1;
        st_d.busy_cnt = CNT_W'(WRITE_CYC);
        if (st_q.wr_is_status) begin
          ns = (st_q.status & ~STATUS_WR_MASK) | (st_q.wr_status & STATUS_WR_MASK);
          if (st_q.wr_status[SB_SEL] && st_q.wr_status[SB_LOCK]) begin // R19
            ns[SB_SEL] = st_q.status[SB_SEL];
            ns[SB_LOCK] = st_q.status[SB_LOCK];
          end
          ns[SB_LOCK] = ns[SB_LOCK] | st_q.status[SB_LOCK]; // R18
          st_d.status[7:2] = ns[7:2];
        end else begin
          st_d.status[SB_SEL] = 1'b0; // R16
        end
      end
    end else if (active && sy.sck_rise) begin // R1
      st_d.sh = nb;
      st_d.bits = st_q.bits + 5'd1;
      unique case (st_q.phase)
        SEPC_CMD: begin
          if (st_q.bits == 5'd7) begin // R6
            st_d.cmd = nb;
            st_d.bits = '0;
            st_d.phase = SEPC_IGNORE;
            if (busy && nb != OP_STATUS_READ) begin
              st_d.phase = SEPC_IGNORE; // R23
            end else begin
              unique case (nb)
                OP_SET_WRITE_LATCH: st_d.status[SB_WEL] = 1'b1; // R9
                OP_CLEAR_WRITE_LATCH: st_d.status[SB_WEL] = 1'b0; // R9
                OP_STATUS_READ: st_d.phase = SEPC_DATA_OUT; // R7
                OP_MEM_READ: st_d.phase = SEPC_ADDR; // R7
                OP_MEM_WRITE: st_d.phase = SEPC_ADDR; // R8
                OP_STATUS_WRITE: st_d.phase = SEPC_DATA_IN; // R8
                default: st_d.phase = SEPC_IGNORE;
              endcase
            end
          end
        end
        SEPC_ADDR: begin
          st_d.addr = {st_q.addr[14:0], sy.sdi};
          if (st_q.bits == 5'd15) begin
            st_d.bits = '0;
            st_d.phase = (st_q.cmd == OP_MEM_READ) ? SEPC_DATA_OUT : SEPC_DATA_IN;
          end
        end
        SEPC_DATA_IN: begin
          if (st_q.bits == 5'd7) begin
            st_d.bits = '0;
            st_d.addr = st_q.addr + 16'd1;
            if (st_q.cmd == OP_STATUS_WRITE) begin
              st_d.wr_status = nb;
              // R15 R13 R14 R20
              st_d.wr_valid = st_q.status[SB_WEL] && !hw_protect;
              st_d.wr_is_status = 1'b1;
            end else begin
              st_d.wr_data = nb;
              st_d.wr_addr = st_q.addr[14:0];
              st_d.wr_is_status = 1'b0;
              st_d.wr_is_id = st_q.status[SB_SEL]; // R16
              st_d.wr_valid = st_q.status[SB_WEL] // R15 R20
                && !in_protected(st_q.status[SB_BP1:SB_BP0], st_q.addr[14:0]) // R12
                && !(st_q.status[SB_SEL] && st_q.status[SB_LOCK]); // R18
            end
          end
        end
        SEPC_DATA_OUT: begin
          // R2: the outgoing byte moves only on falls; rises must leave it alone
          st_d.sh = st_q.sh;
          st_d.bits = st_q.bits;
        end
        default: ;
      endcase
    end else if (active && sy.sck_fall && st_q.phase == SEPC_DATA_OUT) begin // R2
      st_d.so_oe_n = 1'b0;
      if (busy) begin
        stat_out = 8'hff;
      end
      if (st_q.bits == 5'd0 || (st_q.bits == 5'd8)) begin
        st_d.sh = (st_q.cmd == OP_STATUS_READ) ? stat_out
          : read_byte(st_q.status[SB_SEL], st_q.addr); // R16
        st_d.so = st_d.sh[7];
        if (st_q.cmd == OP_MEM_READ && st_q.bits == 5'd8) begin
          st_d.addr = st_q.addr + 16'd1;
          st_d.sh = read_byte(st_q.status[SB_SEL], st_q.addr + 16'd1);
          st_d.so = st_d.sh[7];
        end
        st_d.bits = 5'd1;
      end else begin
        st_d.so = st_q.sh[7 - st_q.bits[2:0]];
        st_d.bits = st_q.bits + 5'd1;
      end
    end
    // clear select bit after a completed read frame
    if (sy.sel_rise && st_q.cmd == OP_MEM_READ && st_q.phase == SEPC_DATA_OUT) begin
      st_d.status[SB_SEL] = 1'b0; // R16
    end
    st_d.status[5] = 1'b0; // R10
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_q <= '{phase: SEPC_IDLE, status: STATUS_RESET, so_oe_n: 1'b1, default: '0};
    end else if (clk_en) begin
      st_q <= st_d;
    end
  end

  // storage update on commit; the page and array are separate
  always_ff @(posedge core_clk) begin
    if (clk_en && commit && !st_q.wr_is_status) begin
      if (st_q.wr_is_id) begin
        id_mem[st_q.wr_addr[IP_BITS-1:0]] <= st_q.wr_data; // R17
      end else begin
        main_mem[st_q.wr_addr[MW_BITS-1:0]] <= st_q.wr_data;
      end
    end
  end

  assign serial_out = st_q.so;
  assign serial_out_oe_n = st_q.so_oe_n;
  assign status_control = st_q.status;

  a_deselect_release: assert property (@(posedge core_clk) disable iff (!arst_n)
    clk_en && sy.sel_n |=> serial_out_oe_n) else $error("output driven while deselected"); // R3
  a_busy_set_commit: assert property (@(posedge core_clk) disable iff (!arst_n)
    commit |=> status_control[SB_BUSY]) else $error("busy not set at commit"); // R11
  a_commit_on_rise: assert property (@(posedge core_clk) disable iff (!arst_n)
    commit |-> sy.sel_rise) else $error("write started without select rise"); // R21
  a_commit_needs_wel: assert property (@(posedge core_clk) disable iff (!arst_n)
    commit |-> $past(status_control[SB_WEL]) || status_control[SB_WEL])
    else $error("write accepted with latch clear"); // R15
  a_bit5_zero: assert property (@(posedge core_clk) disable iff (!arst_n)
    status_control[5] == 1'b0) else $error("status bit 5 not zero"); // R10
  a_lock_sticky: assert property (@(posedge core_clk) disable iff (!arst_n)
    $past(status_control[SB_LOCK]) |-> status_control[SB_LOCK])
    else $error("id lock cleared"); // R18
  a_wel_set_cmd: assert property (@(posedge core_clk) disable iff (!arst_n)
    clk_en && st_q.phase == SEPC_CMD && sy.sck_rise && !sy.sel_fall && !sy.sel_rise
    && active && st_q.bits == 5'd7 && !busy && st_d.cmd == OP_SET_WRITE_LATCH
    |=> status_control[SB_WEL]) else $error("latch not set"); // R9
  a_busy_ignores: assert property (@(posedge core_clk) disable iff (!arst_n)
    clk_en && busy && st_q.phase == SEPC_CMD && sy.sck_rise && active && st_q.bits == 5'd7
    && !sy.sel_rise && st_d.cmd != OP_STATUS_READ |=> st_q.phase == SEPC_IGNORE)
    else $error("command taken while busy"); // R23
endmodule
`default_nettype wire

// [verilog/sepc_pin_sync.sv]
/*
 pin conditioner: three-flop synchronisers on every pin; a level changes
 when the second and third flops agree, edges come from that level.
 assumes pins are asynchronous to core_clk.
*/
`timescale 1ns/1ns
`default_nettype none
module sepc_pin_sync (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic clk_en,
  input wire logic [4:0] pins_in,
  sepc_sync_if.src sy
);
  typedef struct packed {
    logic [4:0] s1;
    logic [4:0] s2;
    logic [4:0] s3;
    logic [4:0] lvl;
  } sepc_sync_state_t;
  sepc_sync_state_t st_q, st_d;
  localparam logic [4:0] LVL_RESET = 5'h1e; // sel, pause, guard idle high; sck low

  // shift chain; level follows only when stage two and three agree
  always_comb begin
    st_d = st_q;
    st_d.s1 = pins_in;
    st_d.s2 = st_q.s1;
    st_d.s3 = st_q.s2;
    for (int i = 0; i < 5; i++) begin
      if (st_q.s2[i] == st_q.s3[i]) begin
        st_d.lvl[i] = st_q.s3[i];
      end
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_q <= {LVL_RESET, LVL_RESET, LVL_RESET, LVL_RESET};
    end else if (clk_en) begin
      st_q <= st_d;
    end
  end

  // pin order: 0 sck, 1 sel_n, 2 pause_n, 3 guard_n, 4 sdi
  assign sy.sck_rise = clk_en && st_d.lvl[0] && !st_q.lvl[0];
  assign sy.sck_fall = clk_en && !st_d.lvl[0] && st_q.lvl[0];
  assign sy.sel_fall = clk_en && !st_d.lvl[1] && st_q.lvl[1];
  assign sy.sel_rise = clk_en && st_d.lvl[1] && !st_q.lvl[1];
  assign sy.sel_n = st_q.lvl[1];
  assign sy.pause_n = st_q.lvl[2];
  assign sy.guard_n = st_q.lvl[3];
  assign sy.sdi = st_q.lvl[4];
endmodule
`default_nettype wire

// [verilog/sepc_pkg.sv]
/*
 package for the serial memory command and protect front end: opcodes,
 status bit positions, protect ranges and cycle counts.
 assumes core_clk at 125 MHz.
*/
package sepc_pkg;
  localparam int CLK_PERIOD_NS = 8;
  localparam int WRITE_CYCLE_US = 5000; // longest self-timed write
  localparam int WRITE_CYCLE_CYC = (WRITE_CYCLE_US * 1000) / CLK_PERIOD_NS;
  // opcodes
  localparam logic [7:0] OP_SET_WRITE_LATCH = 8'h06;
  localparam logic [7:0] OP_CLEAR_WRITE_LATCH = 8'h04;
  localparam logic [7:0] OP_STATUS_READ = 8'h05;
  localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
  localparam logic [7:0] OP_MEM_READ = 8'h03;
  localparam logic [7:0] OP_MEM_WRITE = 8'h02;
  // status bit positions
  localparam int SB_BUSY = 0;
  localparam int SB_WEL = 1;
  localparam int SB_BP0 = 2;
  localparam int SB_BP1 = 3;
  localparam int SB_LOCK = 4;
  localparam int SB_SEL = 6;
  localparam int SB_PPE = 7;
  localparam logic [7:0] STATUS_WR_MASK = 8'hdc; // bits 7,6,4,3,2
  localparam logic [7:0] STATUS_RESET = 8'h00;
  // protect range lower bounds
  localparam logic [14:0] BP_QUARTER = 15'h6000;
  localparam logic [14:0] BP_HALF = 15'h4000;
  localparam int ADDR_BITS = 16;
  localparam int ID_PAGE_BYTES = 64;
  typedef enum logic [2:0] {
    SEPC_IDLE, SEPC_CMD, SEPC_ADDR, SEPC_DATA_IN, SEPC_DATA_OUT, SEPC_IGNORE
  } sepc_phase_t;
endpackage

// [verilog/sepc_sync_if.sv]
/*
 interface carrying the synchronised pin levels and edge pulses from the
 pin conditioner to the command core.
 assumes both ends run on core_clk.
*/
`timescale 1ns/1ns
`default_nettype none
interface sepc_sync_if;
  logic sck_rise;
  logic sck_fall;
  logic sel_n;
  logic sel_fall;
  logic sel_rise;
  logic sdi;
  logic pause_n;
  logic guard_n;
  modport src (output sck_rise, sck_fall, sel_n, sel_fall, sel_rise, sdi, pause_n, guard_n);
  modport dst (input sck_rise, sck_fall, sel_n, sel_fall, sel_rise, sdi, pause_n, guard_n);
endinterface
`default_nettype wire
